// >>> hw/poweron_config_msr_bank.sv
/*
 power-on configuration register bank for two cores, avalon-mm slave.
 assumes straps stable while sys_rst is high and caught at its release.
*/
`timescale 1ns/1ps
`default_nettype none
module poweron_config_msr_bank #(
	parameter bit WRITABLE = 1'b1
) (
	input  wire logic                             clk,
	input  wire logic                             sys_rst,
	input  wire logic                             core_sel,
	input  wire logic [9:0]                       address,
	input  wire logic                             read,
	input  wire logic                             write,
	input  wire logic [31:0]                      writedata,
	input  wire logic [3:0]                       byteenable,
	output logic [31:0]                           readdata,
	output logic [1:0]                            response,
	output logic                                  waitrequest,
	input  wire poweron_config_pkg::strap_type    straps,
	output poweron_config_pkg::feature_type       features
);
	import poweron_config_pkg::*;

	// ========================================================
	// decode helpers
	function automatic logic is_reserved(input logic [9:0] a);
		is_reserved = (a >= RSV_A_LO && a <= RSV_A_HI) ||
			(a >= RSV_B_LO && a <= RSV_B_HI);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be,
		input logic [31:0] wm);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
		merge = (old & ~bm) | (wd & bm);
	endfunction

	// ========================================================
	// bus handshake: one wait cycle, answer on the second edge
	logic        ack;
	logic        req;
	logic [31:0] poweron;
	logic [31:0] platform;
	logic [31:0] poweron_rd;
	logic [31:0] monitor [2];
	logic [31:0] intc [2];
	logic [63:0] cycles [2];
	strap_type   held;
	logic        caught;
	logic        was_rst;

	assign req = (read | write) & ~ack;
	assign waitrequest = (read | write) & ~ack;

	always_ff @(posedge clk) begin
		if (sys_rst)
			ack <= 1'b0;
		else
			ack <= req;
	end

	// ========================================================
	// strap capture after reset release
	always_ff @(posedge clk) begin
		was_rst <= sys_rst;
		if (sys_rst) begin
			caught <= 1'b0;
			held   <= '0;
		end else if (was_rst && !caught) begin
			caught <= 1'b1;
			held   <= straps;
		end
	end

	// ========================================================
	// shared power-on configuration: one copy for both cores
	logic wr_poweron;
	assign wr_poweron = write & ack & (address == IDX_POWERON);

	always_ff @(posedge clk) begin
		if (sys_rst)
			poweron <= POWERON_RESET;
		else if (wr_poweron && WRITABLE)
			poweron <= merge(poweron, writedata, byteenable,
				POWERON_WMASK);
	end

	assign features.data_check  = poweron[BIT_DATA_CHK];
	assign features.resp_check  = poweron[BIT_RESP_CHK];
	assign features.mce_drive   = poweron[BIT_MCE_DRIVE];
	assign features.addr_parity = poweron[BIT_ADDR_PAR];
	assign features.bus_init_signal_drive = poweron[BIT_BUS_INIT_SIGNAL_DRIVE];

	// ========================================================
	// per-core registers
	// separate copy per core
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : per_core
			logic mine;
			assign mine = write & ack & (core_sel == 1'(g));
			always_ff @(posedge clk) begin
				if (sys_rst)
					monitor[g] <= MONITOR_RESET;
				else if (mine && address == IDX_MONITOR_SIZE)
					monitor[g] <= merge(monitor[g], writedata,
						byteenable, '1);
			end
			always_ff @(posedge clk) begin
				if (sys_rst)
					intc[g] <= INTC_RESET;
				else if (mine && address == IDX_INTC_BASE)
					intc[g] <= merge(intc[g], writedata,
						byteenable, INTC_WMASK);
			end
			always_ff @(posedge clk) begin
				if (sys_rst)
					cycles[g] <= '0;
				else if (mine && address == IDX_CYCLE_COUNT)
					cycles[g] <= {32'h00000000, writedata};
				else
					cycles[g] <= cycles[g] + 64'h1;
			end
		end
	endgenerate

	// ========================================================
	// read assembly
	// reserved bits zero
	always_comb begin
		poweron_rd = 32'h00000000;
		poweron_rd[BIT_DATA_CHK]    = poweron[BIT_DATA_CHK];
		poweron_rd[BIT_RESP_CHK]    = poweron[BIT_RESP_CHK];
		poweron_rd[BIT_MCE_DRIVE]   = poweron[BIT_MCE_DRIVE];
		poweron_rd[BIT_ADDR_PAR]    = poweron[BIT_ADDR_PAR];
		poweron_rd[BIT_BUS_INIT_SIGNAL_DRIVE] = poweron[BIT_BUS_INIT_SIGNAL_DRIVE];
		poweron_rd[BIT_TRISTATE]    = held.tristate;
		poweron_rd[BIT_SELF_TEST]   = held.self_test;
		poweron_rd[BIT_MCE_OBS]     = held.mce_observe;
		poweron_rd[BIT_BUS_INIT_SIGNAL_OBS]   = held.bus_init_signal_observe;
		poweron_rd[BIT_VECTOR_1M]   = held.vector_1m;
		poweron_rd[POS_CLUSTER +: 2] = held.cluster_id;
		poweron_rd[BIT_HALF_RATIO]  = held.half_ratio;
		poweron_rd[POS_ARB_ID +: 2] = held.arb_id;
		poweron_rd[POS_BUS_RATIO +: 5] = held.bus_ratio;
		platform = 32'h00000000;
		platform[POS_MAX_RATIO +: 5] = held.max_ratio;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			readdata <= UNMAPPED_DATA;
			response <= RESP_OK;
		end else if (req) begin
			response <= RESP_OK;
			readdata <= UNMAPPED_DATA;
			if (is_reserved(address))
				response <= RESP_SLVERR;
			else if (address == IDX_POWERON)
				readdata <= poweron_rd;
			else if (address == IDX_PLATFORM_ID)
				readdata <= platform;
			else if (address == IDX_MC_ADDR)
				readdata <= MC_ADDR_RESET;
			else if (address == IDX_MC_TYPE)
				readdata <= MC_TYPE_RESET;
			else if (address == IDX_MONITOR_SIZE)
				readdata <= monitor[core_sel];
			else if (address == IDX_CYCLE_COUNT)
				readdata <= cycles[core_sel][31:0];
			else if (address == IDX_INTC_BASE)
				readdata <= intc[core_sel];
			else
				response <= RESP_SLVERR;
		end
	end

	// ========================================================
	// checks
	property p_write_poweron;
		@(posedge clk) disable iff (sys_rst)
		(write && ack && address == IDX_POWERON && byteenable[0]
			&& WRITABLE)
		|=> features.data_check == $past(writedata[BIT_DATA_CHK]);
	endproperty
	a_write_poweron: assert property (p_write_poweron)
		else $error("data check bit did not follow write");

	property p_read_max;
		@(posedge clk) disable iff (sys_rst)
		(read && req && address == IDX_PLATFORM_ID)
		|=> readdata[12:8] == held.max_ratio && readdata[7:0] == 8'h00;
	endproperty
	a_read_max: assert property (p_read_max)
		else $error("max ratio read wrong");

	sequence s_req_rd;
		read && req && address == IDX_POWERON;
	endsequence
	property p_read_cfg;
		@(posedge clk) disable iff (sys_rst)
		s_req_rd ##1 ack |-> readdata[26:22] == held.bus_ratio
			&& readdata[BIT_TRISTATE] == held.tristate
			&& readdata[0] == 1'b0;
	endproperty
	a_read_cfg: assert property (p_read_cfg)
		else $error("config read wrong");

	sequence s_cfg_wr;
		write && ack && address == IDX_POWERON && byteenable[0]
			&& WRITABLE;
	endsequence
	sequence s_cfg_ans;
		s_req_rd ##1 ack;
	endsequence

	property p_rsv;
		@(posedge clk) disable iff (sys_rst)
		(req && is_reserved(address)) |=> response == RESP_SLVERR;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved index answered ok");

	property p_one_wait;
		@(posedge clk) disable iff (sys_rst)
		$rose(read) |-> waitrequest ##1 !waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("answer not after one wait cycle");

	property p_ro_kept;
		@(posedge clk) disable iff (sys_rst)
		wr_poweron |=> (poweron & ~POWERON_WMASK) ==
			($past(poweron) & ~POWERON_WMASK);
	endproperty
	a_ro_kept: assert property (p_ro_kept)
		else $error("read-only bits changed");

	property p_drive;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_wr |=> features.mce_drive ==
			$past(writedata[BIT_MCE_DRIVE]);
	endproperty
	a_drive: assert property (p_drive)
		else $error("drive enable mismatch");

	property p_percore;
		@(posedge clk) disable iff (sys_rst)
		(write && ack && address == IDX_MONITOR_SIZE)
		|=> monitor[~$past(core_sel)] == $past(monitor[~core_sel]);
	endproperty
	a_percore: assert property (p_percore)
		else $error("other core copy changed");

	property p_resp_chk;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_wr |=> features.resp_check ==
			$past(writedata[BIT_RESP_CHK]);
	endproperty
	a_resp_chk: assert property (p_resp_chk)
		else $error("response check bit did not follow write");

	property p_addr_par;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_wr |=> features.addr_parity ==
			$past(writedata[BIT_ADDR_PAR]);
	endproperty
	a_addr_par: assert property (p_addr_par)
		else $error("address parity bit did not follow write");

	property p_bus_init_signal_drv;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_wr |=> features.bus_init_signal_drive ==
			$past(writedata[BIT_BUS_INIT_SIGNAL_DRIVE]);
	endproperty
	a_bus_init_signal_drv: assert property (p_bus_init_signal_drv)
		else $error("bus init drive bit did not follow write");

	property p_ro_build;
		@(posedge clk) disable iff (sys_rst)
		(!WRITABLE && wr_poweron) |=> poweron == $past(poweron);
	endproperty
	a_ro_build: assert property (p_ro_build)
		else $error("read-only build took a write");

	property p_self_test;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[BIT_SELF_TEST] == held.self_test;
	endproperty
	a_self_test: assert property (p_self_test)
		else $error("self-test strap read wrong");

	property p_mce_obs;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[BIT_MCE_OBS] == held.mce_observe;
	endproperty
	a_mce_obs: assert property (p_mce_obs)
		else $error("error observe strap read wrong");

	property p_bus_init_signal_obs;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[BIT_BUS_INIT_SIGNAL_OBS] == held.bus_init_signal_observe;
	endproperty
	a_bus_init_signal_obs: assert property (p_bus_init_signal_obs)
		else $error("init observe strap read wrong");

	property p_vector;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[BIT_VECTOR_1M] == held.vector_1m;
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector strap read wrong");

	property p_cluster;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[POS_CLUSTER +: 2] == held.cluster_id;
	endproperty
	a_cluster: assert property (p_cluster)
		else $error("cluster id read wrong");

	property p_half;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[BIT_HALF_RATIO] == held.half_ratio;
	endproperty
	a_half: assert property (p_half)
		else $error("half ratio read wrong");

	property p_arb;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[POS_ARB_ID +: 2] == held.arb_id;
	endproperty
	a_arb: assert property (p_arb)
		else $error("arbitration id read wrong");

	property p_cfg_rsv;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> (readdata & 32'hF808A061) == 32'h00000000;
	endproperty
	a_cfg_rsv: assert property (p_cfg_rsv)
		else $error("reserved config bits read nonzero");

	property p_cfg_live;
		@(posedge clk) disable iff (sys_rst)
		s_cfg_ans |-> readdata[BIT_DATA_CHK] == features.data_check
			&& readdata[BIT_BUS_INIT_SIGNAL_DRIVE] == features.bus_init_signal_drive;
	endproperty
	a_cfg_live: assert property (p_cfg_live)
		else $error("config read differs from features in force");

	property p_rsv_data;
		@(posedge clk) disable iff (sys_rst)
		(req && is_reserved(address)) |=> readdata == UNMAPPED_DATA;
	endproperty
	a_rsv_data: assert property (p_rsv_data)
		else $error("reserved index read nonzero");

	property p_rsv_ignore;
		@(posedge clk) disable iff (sys_rst)
		(write && ack && is_reserved(address)) |=> $stable(poweron);
	endproperty
	a_rsv_ignore: assert property (p_rsv_ignore)
		else $error("reserved write changed config");

	property p_plat_rsv;
		@(posedge clk) disable iff (sys_rst)
		(read && req && address == IDX_PLATFORM_ID)
		|=> readdata[31:13] == 19'h00000;
	endproperty
	a_plat_rsv: assert property (p_plat_rsv)
		else $error("reserved platform bits read nonzero");
endmodule
`default_nettype wire

// >>> hw/poweron_config_pkg.sv
/*
 package for the power-on configuration register bank: offsets, fields,
 reset values and the carrier structs.
 assumes a 32-bit Avalon-MM slave with word addresses (index x4 = byte).
*/
package poweron_config_pkg;
	// ========================================================
	// register indices (byte address = index * 4)
	localparam logic [9:0] IDX_MC_ADDR      = 10'h000;
	localparam logic [9:0] IDX_MC_TYPE      = 10'h001;
	localparam logic [9:0] IDX_MONITOR_SIZE = 10'h006;
	localparam logic [9:0] IDX_CYCLE_COUNT  = 10'h010;
	localparam logic [9:0] IDX_PLATFORM_ID  = 10'h017;
	localparam logic [9:0] IDX_INTC_BASE    = 10'h01B;
	localparam logic [9:0] IDX_POWERON      = 10'h02A;
	localparam logic [9:0] RSV_A_LO         = 10'h180;
	localparam logic [9:0] RSV_A_HI         = 10'h185;
	localparam logic [9:0] RSV_B_LO         = 10'h188;
	localparam logic [9:0] RSV_B_HI         = 10'h197;
	// ========================================================
	// field positions
	localparam int BIT_DATA_CHK    = 1;
	localparam int BIT_RESP_CHK    = 2;
	localparam int BIT_MCE_DRIVE   = 3;
	localparam int BIT_ADDR_PAR    = 4;
	localparam int BIT_BUS_INIT_SIGNAL_DRIVE = 7;
	localparam int BIT_TRISTATE    = 8;
	localparam int BIT_SELF_TEST   = 9;
	localparam int BIT_MCE_OBS     = 10;
	localparam int BIT_BUS_INIT_SIGNAL_OBS   = 12;
	localparam int BIT_VECTOR_1M   = 14;
	localparam int POS_CLUSTER     = 16;
	localparam int BIT_HALF_RATIO  = 18;
	localparam int POS_ARB_ID      = 20;
	localparam int POS_BUS_RATIO   = 22;
	localparam int POS_MAX_RATIO   = 8;
	// ========================================================
	// reset values and write masks
	localparam logic [31:0] POWERON_WMASK = 32'h0000009E;
	localparam logic [31:0] POWERON_RESET = 32'h0000009E;
	localparam logic [31:0] MC_ADDR_RESET = 32'h00000000;
	localparam logic [31:0] MC_TYPE_RESET = 32'h00000000;
	localparam logic [31:0] MONITOR_RESET = 32'h00000040;
	localparam logic [31:0] INTC_RESET    = 32'hFEE00900;
	localparam logic [31:0] INTC_WMASK    = 32'hFFFFF900;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	localparam logic [1:0]  RESP_OK       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// ========================================================
	// carriers
	typedef struct packed {
		logic       tristate;
		logic       self_test;
		logic       mce_observe;
		logic       bus_init_signal_observe;
		logic       vector_1m;
		logic [1:0] cluster_id;
		logic       half_ratio;
		logic [1:0] arb_id;
		logic [4:0] bus_ratio;
		logic [4:0] max_ratio;
	} strap_type;
	typedef struct packed {
		logic data_check;
		logic resp_check;
		logic mce_drive;
		logic addr_parity;
		logic bus_init_signal_drive;
	} feature_type;
endpackage

// >>> verif/poweron_config_msr_bank_tb.sv
/*
 self-checking testbench for the power-on configuration register bank.
 assumes poweron_config_pkg is compiled first; the bench is the bus master.
*/
`timescale 1ns/1ps
`default_nettype none
module poweron_config_msr_bank_tb;
	import poweron_config_pkg::*;
	logic        clk, sys_rst, core_sel, read, write, waitrequest;
	logic [9:0]  address;
	logic [31:0] writedata, readdata, rd;
	logic [1:0]  response, rsp;
	strap_type   straps, sa;
	feature_type features, features_ro;
	int          bad_count, n_tests, cycles;
	// ========================================================
	// design instances: writable and read-only builds
	poweron_config_msr_bank u_dut (.clk(clk), .sys_rst(sys_rst),
		.core_sel(core_sel), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hF),
		.readdata(readdata), .response(response),
		.waitrequest(waitrequest), .straps(straps), .features(features));
	poweron_config_msr_bank #(.WRITABLE(1'b0)) u_dut_ro (.clk(clk),
		.sys_rst(sys_rst), .core_sel(core_sel), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(4'hF), .readdata(), .response(), .waitrequest(),
		.straps(straps), .features(features_ro));
	// ========================================================
	// clock, timeout and helpers
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic conclude;
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	function automatic logic [31:0] sw(input strap_type s);
		sw = 32'h0;
		sw[8] = s.tristate;
		sw[9] = s.self_test;
		sw[10] = s.mce_observe;
		sw[12] = s.bus_init_signal_observe;
		sw[14] = s.vector_1m;
		sw[17:16] = s.cluster_id;
		sw[18] = s.half_ratio;
		sw[21:20] = s.arb_id;
		sw[26:22] = s.bus_ratio;
	endfunction
	function automatic logic [31:0] fw(input logic [31:0] w);
		fw = {27'h0, w[1], w[2], w[3], w[4], w[7]};
	endfunction
	task automatic bus(input logic wr, input logic c, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge clk);
		core_sel <= c;
		read <= ~wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		rsp = response;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// ========================================================
	// scenarios
	task automatic t_reset(input strap_type s);
		@(posedge clk);
		sys_rst <= 1'b1;
		straps <= s;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
		check("features", 32'h1F, {27'h0, features});
		bus(1'b0, 1'b1, IDX_POWERON, 32'h0);
		check("poweron", POWERON_RESET | sw(s), rd);
		check("resp", {30'h0, RESP_OK}, {30'h0, rsp});
		bus(1'b1, 1'b0, IDX_PLATFORM_ID, 32'hFFFFFFFF);
		bus(1'b0, 1'b0, IDX_PLATFORM_ID, 32'h0);
		check("platform", {19'h0, s.max_ratio, 8'h0}, rd);
	endtask
	task automatic t_bits(input strap_type s);
		logic [31:0] w;
		for (int i = 0; i < 32; i++) begin
			w = 32'h1 << i;
			if ((w & POWERON_WMASK) != 32'h0) begin
				bus(1'b1, 1'b0, IDX_POWERON, w);
				bus(1'b0, 1'b1, IDX_POWERON, 32'h0);
				check("poweron_bit", w | sw(s), rd);
				check("features", fw(w), {27'h0, features});
				check("features_ro", 32'h1F, {27'h0, features_ro});
			end
		end
		bus(1'b1, 1'b0, IDX_POWERON, 32'hFFFFFFFF);
		bus(1'b0, 1'b0, IDX_POWERON, 32'h0);
		check("poweron_all", POWERON_WMASK | sw(s), rd);
		check("features", 32'h1F, {27'h0, features});
	endtask
	task automatic t_cores;
		bus(1'b1, 1'b0, IDX_INTC_BASE, 32'hABCDE000);
		bus(1'b0, 1'b1, IDX_INTC_BASE, 32'h0);
		check("intc_core1", INTC_RESET, rd);
		bus(1'b0, 1'b0, IDX_INTC_BASE, 32'h0);
		check("intc_core0", (32'hABCDE000 & INTC_WMASK) |
			(INTC_RESET & ~INTC_WMASK), rd);
		bus(1'b1, 1'b1, IDX_MONITOR_SIZE, 32'h00000080);
		bus(1'b0, 1'b0, IDX_MONITOR_SIZE, 32'h0);
		check("monitor_core0", MONITOR_RESET, rd);
		bus(1'b0, 1'b1, IDX_MONITOR_SIZE, 32'h0);
		check("monitor_core1", 32'h00000080, rd);
		bus(1'b0, 1'b0, IDX_MC_TYPE, 32'h0);
		check("mc_type", MC_TYPE_RESET, rd);
		check("mc_type_resp", {30'h0, RESP_OK}, {30'h0, rsp});
	endtask
	task automatic t_reserved(input strap_type s);
		logic [9:0] adr [4];
		adr = '{RSV_A_LO, RSV_A_HI, RSV_B_LO, RSV_B_HI};
		foreach (adr[i]) begin
			bus(1'b1, 1'b0, adr[i], 32'hFFFFFFFF);
			bus(1'b0, 1'b0, adr[i], 32'h0);
			check("reserved", UNMAPPED_DATA, rd);
			check("reserved_resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		end
		bus(1'b0, 1'b0, IDX_POWERON, 32'h0);
		check("poweron_kept", POWERON_WMASK | sw(s), rd);
	endtask
	// ========================================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		core_sel = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 10'h0;
		writedata = 32'h0;
		sa = strap_type'(20'hAC6AA);
		straps = sa;
		bad_count = 0;
		n_tests = 0;
		cycles = 0;
		t_reset(sa);
		t_bits(sa);
		t_cores();
		t_reserved(sa);
		sa = strap_type'(~sa);
		t_reset(sa);
		t_bits(sa);
		conclude();
	end
endmodule
`default_nettype wire
